/* File: lisa_pkg.sv */
package lisa_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CODE_LOW   = 8'h02;
    localparam logic [7:0] ADDR_CODE_HIGH  = 8'h03;
    localparam logic [7:0] ADDR_SYNC_ADJ   = 8'h04;
    localparam logic [7:0] ADDR_PART_REV   = 8'h05;
    localparam logic [7:0] RESET_BYTE      = 8'h00;
    localparam logic [7:0] UNMAPPED_BYTE   = 8'h00;

    // ------------------------------------------------------------------
    // field positions and widths
    // ------------------------------------------------------------------
    localparam int HIGH_USED_BITS  = 6;
    localparam int HSYNC_SEL_LSB   = 0;
    localparam int VSYNC_SEL_LSB   = 3;
    localparam int SEL_BITS        = 3;
    localparam int SWAP_BIT        = 6;
    localparam int ADJ_USED_BITS   = 7;
    localparam int DATA_BITS       = 14;
    localparam int CRC_BITS        = 6;
    localparam int CODE_BITS       = 20;
    localparam int SYNC_MAX_DELAY  = 7;

    // ------------------------------------------------------------------
    // line numbers, crc and chroma phases
    // ------------------------------------------------------------------
    localparam int              LINE_BITS      = 10;
    localparam logic [9:0]      LINE_FIRST     = 10'h001;
    localparam logic [9:0]      LINE_ID_LINE   = 10'h014;
    localparam logic [9:0]      WIDESCREEN_LINE = 10'h017;
    localparam logic [5:0]      CRC_SEED       = 6'h3F;
    localparam logic [1:0]      PHASE_CB       = 2'h0;
    localparam logic [1:0]      PHASE_CR       = 2'h2;

    // crc over the 14 data bits, lowest code bit first, x^6 + x + 1
    function automatic logic [5:0] lisa_crc6(input logic [13:0] data);
        logic [5:0] crc;
        logic       fb;
        crc = CRC_SEED;
        for (int i = 0; i < DATA_BITS; i++) begin
            fb  = data[i] ^ crc[5];
            crc = {crc[4:1], crc[0] ^ fb, fb};
        end
        return crc;
    endfunction

endpackage

/* File: lisa_sync_delay.sv */
`timescale 1ns/1ps

// delays a synchronised sync level by a selectable count of system clocks
module lisa_sync_delay #(
    parameter int MAX_DELAY = 7
) (
    input  wire logic                         clock_in,
    input  wire logic                         rst_n_in,
    input  wire logic                         level_in,
    input  wire logic [$clog2(MAX_DELAY+1)-1:0] sel_in,
    output logic                              level_out
);
    import lisa_pkg::*;

    logic [MAX_DELAY:1] taps;
    logic [MAX_DELAY:0] tap_view;

    // ------------------------------------------------------------------
    // tap chain
    // ------------------------------------------------------------------
    // one flop per tap from 1 up; tap 0 is level_in itself, and the output flop keeps selection glitch free
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            taps <= '0;
        end else begin
            taps <= {taps[MAX_DELAY-1:1], level_in};
        end
    end

    assign tap_view = {taps, level_in};

    // output register keeps the data output from a flop; adds one fixed cycle
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            level_out <= 1'b0;
        end else begin
            level_out <= tap_view[sel_in];
        end
    end

endmodule

/* File: lisa_regs.sv */
`timescale 1ns/1ps

module lisa_regs #(
    parameter logic [5:0] PART_CODE = 6'h2A,  // arbitrary value
    parameter logic [1:0] REV_CODE  = 2'h1    // arbitrary value
) (
    input  wire logic                         clock_in,
    input  wire logic                         rst_n_in,
    input  wire logic                         reg_wr_in,
    input  wire logic                         reg_rd_in,
    input  wire logic [7:0]                   reg_addr_in,
    input  wire logic [7:0]                   reg_wdata_in,
    output logic      [7:0]                   reg_rdata_out,
    input  wire logic                         tv_standard_select_in,
    input  wire logic                         line_id_code_en_in,
    input  wire logic                         widescreen_signal_en_in,
    input  wire logic                         external_sync_in,
    input  wire logic                         hsync_in,
    input  wire logic                         vsync_in,
    input  wire logic [7:0]                   pixel_in,
    output logic                              hsync_adj_out,
    output logic                              vsync_adj_out,
    output logic      [7:0]                   pixel_out,
    output logic                              code_insert_out,
    output logic      [lisa_pkg::CODE_BITS-1:0] code_word_out
);
    import lisa_pkg::*;

    logic                   rst_meta, rst_n;
    logic [7:0]             code_low, wss_low;
    logic [5:0]             code_high, wss_high;
    logic [6:0]             sync_adjust;
    logic                   wss_pending;
    logic                   hs_meta, hs_sync, vs_meta, vs_sync;
    logic [7:0]             pix_meta, pix_sync;
    logic                   hs_prev, vs_prev, hs_rise, vs_rise;
    logic [LINE_BITS-1:0]   line_cnt, next_line;
    logic                   ntsc_on, pal_on, at_target, wss_load;
    logic [DATA_BITS-1:0]   ntsc_data;
    logic [CODE_BITS-1:0]   next_word;
    logic [7:0]             pix_sh [0:4];
    logic [1:0]             phase_new, phase_d1, phase_d2;
    logic                   wr_low, wr_high;

    // ------------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------------
    // reset asserts at once but releases on the clock to avoid recovery races
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // first stage feeds only the second stage
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            hs_meta  <= 1'b0;
            hs_sync  <= 1'b0;
            vs_meta  <= 1'b0;
            vs_sync  <= 1'b0;
            pix_meta <= RESET_BYTE;
            pix_sync <= RESET_BYTE;
        end else begin
            hs_meta  <= hsync_in;
            hs_sync  <= hs_meta;
            vs_meta  <= vsync_in;
            vs_sync  <= vs_meta;
            pix_meta <= pixel_in;
            pix_sync <= pix_meta;
        end
    end

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    assign wr_low  = reg_wr_in && (reg_addr_in == ADDR_CODE_LOW);
    assign wr_high = reg_wr_in && (reg_addr_in == ADDR_CODE_HIGH);

    // data bytes are stored in every mode; reserved high bits are dropped
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            code_low    <= RESET_BYTE;
            code_high   <= '0;
            sync_adjust <= '0;
        end else if (reg_wr_in) begin
            if (wr_low) code_low <= reg_wdata_in;
            if (wr_high) code_high <= reg_wdata_in[HIGH_USED_BITS-1:0];
            if (reg_addr_in == ADDR_SYNC_ADJ) begin
                sync_adjust <= reg_wdata_in[ADJ_USED_BITS-1:0];
            end
        end
    end

    // read data from a flop; unmapped offsets answer zero
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_out <= RESET_BYTE;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                ADDR_CODE_LOW:  reg_rdata_out <= code_low;
                ADDR_CODE_HIGH: reg_rdata_out <= {2'h0, code_high};
                ADDR_SYNC_ADJ:  reg_rdata_out <= {1'b0, sync_adjust};
                ADDR_PART_REV:  reg_rdata_out <= {REV_CODE, PART_CODE};
                default:        reg_rdata_out <= UNMAPPED_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // widescreen staging
    // ------------------------------------------------------------------
    // the high byte write marks a whole word; a new write beats the clear
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            wss_pending <= 1'b0;
            wss_low     <= RESET_BYTE;
            wss_high    <= '0;
        end else begin
            if (wss_load) begin
                wss_low  <= code_low;
                wss_high <= code_high;
            end
            if (wr_high) wss_pending <= 1'b1;
            else if (wss_load) wss_pending <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // sync delay
    // ------------------------------------------------------------------
    lisa_sync_delay #(.MAX_DELAY(SYNC_MAX_DELAY)) u_hsync_delay (
        .clock_in  (clock_in),
        .rst_n_in  (rst_n),
        .level_in  (hs_sync),
        .sel_in    (sync_adjust[HSYNC_SEL_LSB +: SEL_BITS]),
        .level_out (hsync_adj_out)
    );

    lisa_sync_delay #(.MAX_DELAY(SYNC_MAX_DELAY)) u_vsync_delay (
        .clock_in  (clock_in),
        .rst_n_in  (rst_n),
        .level_in  (vs_sync),
        .sel_in    (sync_adjust[VSYNC_SEL_LSB +: SEL_BITS]),
        .level_out (vsync_adj_out)
    );

    // ------------------------------------------------------------------
    // line counting and code insertion
    // ------------------------------------------------------------------
    // edges only count in external sync mode; free-running timing lives elsewhere
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            hs_prev  <= 1'b0;
            vs_prev  <= 1'b0;
            line_cnt <= '0;
        end else begin
            hs_prev <= hsync_adj_out;
            vs_prev <= vsync_adj_out;
            if (vs_rise) line_cnt <= LINE_FIRST;
            else if (hs_rise) line_cnt <= next_line;
        end
    end

    assign hs_rise   = external_sync_in && hsync_adj_out && !hs_prev;
    assign vs_rise   = external_sync_in && vsync_adj_out && !vs_prev;
    assign next_line = line_cnt + LINE_FIRST;
    assign ntsc_on   = line_id_code_en_in && !tv_standard_select_in;
    assign pal_on    = widescreen_signal_en_in && tv_standard_select_in;
    assign at_target = hs_rise && !vs_rise &&
                       ((ntsc_on && next_line == LINE_ID_LINE) ||
                        (pal_on && next_line == WIDESCREEN_LINE));
    assign wss_load  = at_target && pal_on && wss_pending;

    // reorder register bits into code bit order, index 0 is code bit 1
    always_comb begin
        for (int i = 0; i < HIGH_USED_BITS; i++) begin
            ntsc_data[i] = code_high[HIGH_USED_BITS-1-i];
        end
        for (int i = 0; i < 8; i++) begin
            ntsc_data[HIGH_USED_BITS+i] = code_low[7-i];
        end
        if (pal_on) begin
            next_word = {6'h00, (wss_load ? {code_high, code_low}
                                          : {wss_high, wss_low})};
        end else begin
            next_word = {lisa_crc6(ntsc_data), ntsc_data};
        end
    end

    // word holds through the whole target line and stays until the next one
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            code_insert_out <= 1'b0;
            code_word_out   <= '0;
        end else if (hs_rise || vs_rise) begin
            code_insert_out <= at_target;
            if (at_target) code_word_out <= next_word;
        end
    end

    // ------------------------------------------------------------------
    // chroma swap
    // ------------------------------------------------------------------
    // two cycles of latency let a Cr sample move ahead of its Cb partner
    always_ff @(posedge clock_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 5; i++) pix_sh[i] <= RESET_BYTE;
            phase_new <= PHASE_CB;
            phase_d1  <= PHASE_CB;
            phase_d2  <= PHASE_CB;
            pixel_out <= RESET_BYTE;
        end else begin
            pix_sh[0] <= pix_sync;
            for (int i = 1; i < 5; i++) pix_sh[i] <= pix_sh[i-1];
            phase_new <= hs_rise ? PHASE_CB : phase_new + 2'h1;
            phase_d1  <= phase_new;
            phase_d2  <= phase_d1;
            if (sync_adjust[SWAP_BIT] && phase_d2 == PHASE_CB) begin
                pixel_out <= pix_sh[0];
            end else if (sync_adjust[SWAP_BIT] && phase_d2 == PHASE_CR) begin
                pixel_out <= pix_sh[4];
            end else begin
                pixel_out <= pix_sh[2];
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    // the first line 23 that finds a whole word waiting
    sequence seq_commit_line;
        at_target && pal_on && wss_pending;
    endsequence

    AST_HSYNC_MAX: assert property (@(posedge clock_in) disable iff (!rst_n)
        (sync_adjust[2:0] == 3'h7 && $past(sync_adjust[2:0]) == 3'h7)
        |-> hsync_adj_out == $past(hs_sync, 8))
        else $error("hsync delay of seven is wrong");

    AST_VSYNC_ZERO: assert property (@(posedge clock_in) disable iff (!rst_n)
        (sync_adjust[5:3] == 3'h0 && $past(sync_adjust[5:3]) == 3'h0)
        |-> vsync_adj_out == $past(vs_sync))
        else $error("vsync delay of zero is wrong");

    AST_PART_READ: assert property (@(posedge clock_in) disable iff (!rst_n)
        (reg_rd_in && reg_addr_in == ADDR_PART_REV) |=> reg_rdata_out == {REV_CODE, PART_CODE})
        else $error("identification read mismatch");

    AST_CRC_TAIL: assert property (@(posedge clock_in) disable iff (!rst_n)
        (code_insert_out && !tv_standard_select_in)
        |-> code_word_out[19:14] == lisa_crc6(code_word_out[13:0]))
        else $error("line id crc mismatch");

    AST_LOW_MAP: assert property (@(posedge clock_in) disable iff (!rst_n)
        (at_target && ntsc_on && !reg_wr_in)
        |=> code_word_out[6] == code_low[7] && code_word_out[13] == code_low[0])
        else $error("low byte bit order wrong");

    AST_WSS_COMMIT: assert property (@(posedge clock_in) disable iff (!rst_n)
        seq_commit_line |=> code_insert_out && code_word_out[7:0] == $past(code_low)
                            && code_word_out[13:8] == $past(code_high))
        else $error("widescreen word not sent on next line 23");

    AST_HOLD_DATA: assert property (@(posedge clock_in) disable iff (!rst_n)
        !reg_wr_in |=> $stable(code_low) && $stable(code_high))
        else $error("data register changed without a write");

    AST_NO_CODE: assert property (@(posedge clock_in) disable iff (!rst_n)
        ((hs_rise || vs_rise) && !ntsc_on && !pal_on) |=> !code_insert_out)
        else $error("code inserted with no matching mode");

    AST_SWAP_CB: assert property (@(posedge clock_in) disable iff (!rst_n)
        (sync_adjust[SWAP_BIT] && phase_d2 == PHASE_CB) |=> pixel_out == $past(pix_sh[0]))
        else $error("chroma swap did not pick Cr");

endmodule

/* File: lisa_video_src.sv */
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// video source at the encoder's sync and pixel pins
// ----------------------------------------------------------------------
module lisa_video_src #(
    parameter int LINE_LEN = 24,
    parameter int LINES    = 26
) (
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    output logic            hsync_out,
    output logic            vsync_out,
    output logic      [7:0] pixel_out
);
    int pos;
    int line;

    // free-running raster; vsync leads hsync inside line 0 so the line count restarts cleanly
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pos       <= 0;
            line      <= 0;
            hsync_out <= 1'b0;
            vsync_out <= 1'b0;
            pixel_out <= 8'h00;
        end else begin
            pos       <= (pos == LINE_LEN - 1) ? 0 : pos + 1;
            if (pos == LINE_LEN - 1) line <= (line == LINES - 1) ? 0 : line + 1;
            hsync_out <= (pos >= 8) && (pos < 12);
            vsync_out <= (line == 0) && (pos < 4);
            pixel_out <= pixel_out + 8'h01;         // new value each cycle, so no stale sample passes
        end
    end
endmodule

/* File: lisa_regs_tb.sv */
`timescale 1ns/1ps

module lisa_regs_tb;
    import lisa_pkg::*;
    localparam logic [5:0] T_PART = 6'h15;  // arbitrary value
    localparam logic [1:0] T_REV  = 2'h2;   // arbitrary value
    logic        clock_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        wr_q = 1'b0, rd_q = 1'b0, tv_std = 1'b0, lid_en = 1'b0, ws_en = 1'b0;
    logic        ext_sync = 1'b0;
    logic [7:0]  addr_q = 8'h00, wdata_q = 8'h00, lfsr_q = 8'h32, lo, hi;
    logic        hs, vs, hs_adj, vs_adj, ins, hs_q = 1'b0, vs_q = 1'b0;
    logic [7:0]  pix, pix_o, rdata;
    logic [19:0] word, got_word;
    logic [15:0] hh = 16'h0000, vh = 16'h0000;
    logic [7:0]  ph [0:8];
    logic [7:0]  model [0:7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, {T_REV, T_PART}, 8'h00, 8'h00};
    int          n_fail = 0, comparisons = 0, quiet = 40, n3 = 0, n7 = 0;
    int          line = 0, pos = 0, n_ins = 0, ins_line = 0, n_vs = 0, nline;

    always #12.5 clock_in = ~clock_in;

    lisa_regs #(.PART_CODE(T_PART), .REV_CODE(T_REV)) i_lisa_regs (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_wr_in(wr_q), .reg_rd_in(rd_q),
        .reg_addr_in(addr_q), .reg_wdata_in(wdata_q), .reg_rdata_out(rdata),
        .tv_standard_select_in(tv_std), .line_id_code_en_in(lid_en),
        .widescreen_signal_en_in(ws_en), .external_sync_in(ext_sync), .hsync_in(hs),
        .vsync_in(vs), .pixel_in(pix), .hsync_adj_out(hs_adj), .vsync_adj_out(vs_adj),
        .pixel_out(pix_o), .code_insert_out(ins), .code_word_out(word));

    lisa_video_src i_lisa_video_src (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .hsync_out(hs), .vsync_out(vs), .pixel_out(pix));

    // ------------------------------------------------------------------
    // reference model helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // written out independently: shift left, feedback into bits 1 and 0
    function automatic logic [19:0] ntsc_word(input logic [7:0] l, input logic [7:0] h);
        logic [13:0] d;
        logic [5:0]  c;
        logic        fb;
        for (int i = 0; i < 14; i++) d[i] = (i < 6) ? h[5 - i] : l[13 - i];
        c = 6'h3F;
        for (int i = 0; i < 14; i++) begin
            fb = d[i] ^ c[5];
            c  = {c[4:0], 1'b0} ^ (fb ? 6'h03 : 6'h00);
        end
        return {c, d};
    endfunction

    task automatic check(input logic [19:0] seen, input logic [19:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // one-cycle strobes; an idle edge between calls keeps every driver single per step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        wr_q    <= 1'b1;
        addr_q  <= a;
        wdata_q <= d;
        @(posedge clock_in);
        wr_q    <= 1'b0;
        if (a == ADDR_CODE_LOW) model[2] = d;
        if (a == ADDR_CODE_HIGH) model[3] = d & 8'h3F;
        if (a == ADDR_SYNC_ADJ) model[4] = d & 8'h7F;
        if (a == ADDR_SYNC_ADJ) quiet = 16;  // delay taps settle after a change
    endtask

    task automatic rd_chk(input logic [7:0] a);
        @(posedge clock_in);
        rd_q   <= 1'b1;
        addr_q <= a;
        @(posedge clock_in);
        rd_q   <= 1'b0;
        @(negedge clock_in);
        check(rdata, model[a[2:0]], "register read");
    endtask

    task automatic wait_vs(input int target);
        for (int k = 0; k < 2000 && n_vs < target; k++) @(negedge clock_in);
        if (n_vs < target) begin
            n_fail++;
            $display("unexpected at %0t: no vsync seen", $time);
            report_and_stop();
        end
    endtask

    // skips to a frame start, then counts inserted lines over one whole frame
    task automatic frame;
        wait_vs(n_vs + 1);
        n_ins = 0;
        wait_vs(n_vs + 1);
    endtask

    // ------------------------------------------------------------------
    // cycle monitor: delay and swap taps, line numbering, insert capture
    // ------------------------------------------------------------------
    always @(negedge clock_in) begin
        hh = {hh[14:0], hs};
        vh = {vh[14:0], vs};
        for (int i = 8; i > 0; i--) ph[i] = ph[i - 1];
        ph[0] = pix;
        if (quiet > 0) quiet--;
        else begin
            check(hs_adj, hh[3 + model[4][2:0]], "hsync delay");
            check(vs_adj, vh[3 + model[4][5:3]], "vsync delay");
            // two pin flops, three shift stages and the output flop: six cycles
            if (!model[4][6]) check(pix_o, ph[6], "pixel order");
            else if (pix_o === ph[4]) n3++;
            else if (pix_o === ph[8]) n7++;
            else check(pix_o, ph[6], "swapped pixel");
        end
        if (vs_adj && !vs_q) n_vs++;
        if (vs_adj && !vs_q) line = 0;
        if (hs_adj && !hs_q) line++;
        pos = (hs_adj && !hs_q) ? 0 : pos + 1;
        if (pos == 12 && ins === 1'b1) begin
            n_ins++;
            ins_line = line;
            got_word = word;
        end
        hs_q = hs_adj;
        vs_q = vs_adj;
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clock_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        for (int a = 0; a < 8; a++) rd_chk(8'(a));
        wr(ADDR_PART_REV, 8'hFF);
        rd_chk(ADDR_PART_REV);
        wr(8'h07, 8'h5A);
        rd_chk(8'h07);
        $display("test reset_and_id done");
        @(posedge clock_in);
        ext_sync <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            wr(ADDR_SYNC_ADJ, {1'b0, s[0], 3'(7 - s), 3'(s)});
            rd_chk(ADDR_SYNC_ADJ);
            frame();
        end
        check(20'(n3 > 0), 20'h00001, "swap gives later sample");
        check(20'(n7 > 0), 20'h00001, "swap gives earlier sample");
        $display("test sync_delay done");
        @(posedge clock_in);
        lid_en <= 1'b1;
        for (int r = 0; r < 2; r++) begin
            lfsr_q = lfsr(lfsr_q);
            lo     = lfsr_q;
            lfsr_q = lfsr(lfsr_q);
            hi     = lfsr_q & 8'h3F;
            wr(ADDR_CODE_LOW, lo);
            wr(ADDR_CODE_HIGH, hi);
            rd_chk(ADDR_CODE_HIGH);
            rd_chk(ADDR_CODE_LOW);
            repeat (2) begin
                frame();
                check(20'(n_ins), 20'h00001, "one id line per frame");
                check(got_word, ntsc_word(lo, hi), "id word and crc");
            end
        end
        nline = ins_line;
        $display("test line_id done");
        @(posedge clock_in);
        tv_std <= 1'b1;
        lid_en <= 1'b0;
        ws_en  <= 1'b1;
        wr(ADDR_CODE_LOW, lo);
        wr(ADDR_CODE_HIGH, hi);
        frame();
        check(got_word, {6'h00, hi[5:0], lo}, "widescreen groups");
        check(20'(ins_line - nline), 20'h00003, "widescreen three lines after id");
        wr(ADDR_CODE_LOW, ~lo);
        frame();
        check(got_word, {6'h00, hi[5:0], lo}, "low byte alone holds old code");
        wr(ADDR_CODE_HIGH, ~hi & 8'h3F);
        frame();
        check(got_word, {6'h00, ~hi[5:0], ~lo}, "high byte commits");
        $display("test widescreen done");
        @(posedge clock_in);
        ws_en <= 1'b0;
        lid_en <= 1'b1;  // line id enable under pal is not a matching mode
        frame();
        check(20'(n_ins), 20'h00000, "no mode no insert");
        @(posedge clock_in);
        ws_en    <= 1'b1;
        ext_sync <= 1'b0;
        frame();
        check(20'(n_ins), 20'h00000, "internal sync no insert");
        $display("test no_insert done");
        report_and_stop();
    end
endmodule
